// *** core/hspm_pin_mux.sv ***
// Purpose: pin-function selection and strap capture for host and serial pins
// Assumes: inputs synchronous to mclk; master reset held high resets the block
// Notes: uart/floppy/printer/ir internals live elsewhere; this block only steers pins
// Function
// [R1]: printer sense high routes printer, low floppy
// [R2]: printer detect enable bit gates sense input
// [R3]: gpio/irq select chooses irq outputs or gpio
// [R4]: serial irq mode drives serial interrupt pin
// [R5]: serial irq mode takes pci clock input
// [R6]: software matches clock select to reference clock
// [R7]: full decode low turns modem pins into address
// [R8]: uart A output strap loads full-decode default
// [R9]: config port strap selects 250h or 3F0h
// [R10]: pnp default strap loads its default bit
// [R11]: gpio/irq strap loads select default bit
// [R12]: terminal count from host ends dma transfer
// [R13]: smi low on acpi-class power events
// [R14]: acpi irq placed on pnp-selected line
// [R15]: fast ir pin direction from ir register
// [R16]: low data-set-ready means modem ready
// [R17]: low carrier-detect means carrier present
// [R18]: low ring-indicator means ring arriving
// [R19]: drive data-terminal-ready low when ready
// [R20]: drive request-to-send low when ready
// [R21]: uart B output carries ir transmit
// [R22]: uart B input used as ir receive
// [R23]: master reset active high resets device
// [R24]: straps captured at reset release, then held
//
// The placing of the registers and register access over Wishbone were left to the implementer.
module hspm_pin_mux
  import hspm_pkg::*;
#(
  parameter int IRQ_LINES = 8
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic master_reset,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  input wire logic strap_full_decode,
  input wire logic strap_config_port_select,
  input wire logic strap_pnp_default,
  input wire logic strap_gpio_irq_select,
  input wire logic printer_not_floppy_sense,
  output logic printerSelected,
  output logic floppySelected,
  input wire logic irqRequestA,
  input wire logic irqRequestB,
  input wire logic [1:0] gpioOut,
  input wire logic [1:0] gpioOe,
  output logic irqPinA,
  output logic irqPinB,
  output logic gpio_line_0,
  output logic gpio_line_1,
  output logic irqPinAOe_n,
  output logic irqPinBOe_n,
  input wire logic parallelIrq,
  input wire logic serialIrqData,
  output logic serial_interrupt_out,
  output logic parallelIrqOut,
  input wire logic pciClkPin,
  output logic pciClkTick,
  input wire logic [3:0] modemAddrPins,
  output logic [15:12] sysAddrHigh,
  output logic fullDecodeActive,
  output logic [15:0] configPortAddr,
  input wire logic terminal_count,
  input wire logic dmaActive,
  output logic dmaEnd,
  input wire logic pmEvent,
  output logic system_mgmt_irq_n,
  output logic [IRQ_LINES-1:0] acpiIrqLines,
  input wire logic fastIrPinIn,
  input wire logic irModeSel0,
  output logic fast_ir_receive,
  output logic fastIrPinOut,
  output logic fastIrPinOe_n,
  input wire hspm_modem_in_t modemPinsA,
  input wire hspm_modem_in_t modemPinsB,
  output hspm_modem_in_t modemStatA,
  output hspm_modem_in_t modemStatB,
  input wire hspm_modem_out_t modemReqA,
  input wire hspm_modem_out_t modemReqB,
  output hspm_modem_out_t modemPinsOutA,
  output hspm_modem_out_t modemPinsOutB,
  input wire logic uartBTxData,
  input wire logic irTxData,
  input wire logic uart_b_serial_in,
  output logic uart_b_serial_out,
  output logic uartBRxData,
  output logic ir_receive_shared
);
  logic [7:0] config_reg_16_ff, nxt_config_reg_16;
  logic [7:0] config_reg_2c_ff, nxt_config_reg_2c;
  logic [7:0] config_reg_2e_ff, nxt_config_reg_2e;
  logic [7:0] config_reg_31_ff, nxt_config_reg_31;
  logic [7:0] hsir_ff, nxt_hsir;
  logic [7:0] pnp_ff, nxt_pnp;
  logic ack_ff;
  logic [31:0] rdat_ff;
  logic pciClkPrev_ff;
  logic smiN_ff;
  logic dmaEnd_ff;
  hspm_state_t state_ff, nxt_state;
  logic resetAct;
  logic wrStrobe, rdStrobe;
  logic [31:0] rdMux;
  logic printerDetEn, gpioMode, serialMode, fullDecode, irOutMode, irFunc;

  function automatic logic [7:0] merge_byte(input logic [7:0] old, input logic [7:0] wd,
                                            input logic lane);
    merge_byte = lane ? wd : old;
  endfunction

  // either reset input holds everything in reset
  assign resetAct = !rst_n || master_reset; // [R23]

  assign wrStrobe = wb_cyc_i && wb_stb_i && wb_we_i && !ack_ff && state_ff == HSPM_ST_RUN;
  assign rdStrobe = wb_cyc_i && wb_stb_i && !wb_we_i && !ack_ff;

  // state walk: reset -> capture straps once -> run
  always_comb begin
    unique case (state_ff)
      HSPM_ST_RESET: nxt_state = HSPM_ST_CAPTURE;
      HSPM_ST_CAPTURE: nxt_state = HSPM_ST_RUN;
      HSPM_ST_RUN: nxt_state = HSPM_ST_RUN;
      default: nxt_state = HSPM_ST_RESET;
    endcase
  end

  always_comb begin
    nxt_config_reg_16 = config_reg_16_ff;
    nxt_config_reg_2c = config_reg_2c_ff;
    nxt_config_reg_2e = config_reg_2e_ff;
    nxt_config_reg_31 = config_reg_31_ff;
    nxt_hsir = hsir_ff;
    nxt_pnp = pnp_ff;
    if (state_ff == HSPM_ST_CAPTURE) begin
      // straps sampled once at release, so later pin use cannot disturb them
      nxt_config_reg_2e[HSPM_BIT_STRAPFD] = strap_full_decode; // [R8] [R24]
      nxt_config_reg_16[HSPM_BIT_CFGPORT] = strap_config_port_select; // [R9] [R24]
      nxt_config_reg_16[HSPM_BIT_PNPDEF] = strap_pnp_default; // [R10] [R24]
      nxt_config_reg_16[HSPM_BIT_GPIOIRQ] = strap_gpio_irq_select; // [R11] [R24]
      // full decode (active low) defaults from the uart A strap as well
      nxt_config_reg_16[HSPM_BIT_FULLDEC] = strap_full_decode;
    end else if (wrStrobe && wb_sel_i[0]) begin
      unique case (wb_adr_i)
        HSPM_OFF_CONFIG_REG_16: nxt_config_reg_16 = merge_byte(config_reg_16_ff, wb_dat_i[7:0], 1'b1);
        HSPM_OFF_CONFIG_REG_2C: nxt_config_reg_2c = merge_byte(config_reg_2c_ff, wb_dat_i[7:0], 1'b1); // [R6]
        HSPM_OFF_CONFIG_REG_2E: nxt_config_reg_2e = merge_byte(config_reg_2e_ff, wb_dat_i[7:0], 1'b1);
        HSPM_OFF_CONFIG_REG_31: nxt_config_reg_31 = merge_byte(config_reg_31_ff, wb_dat_i[7:0], 1'b1);
        HSPM_OFF_HSIR: nxt_hsir = merge_byte(hsir_ff, wb_dat_i[7:0], 1'b1);
        HSPM_OFF_PNP: nxt_pnp = merge_byte(pnp_ff, wb_dat_i[7:0], 1'b1);
        default: nxt_pnp = pnp_ff;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (resetAct) begin
      state_ff <= HSPM_ST_RESET;
      config_reg_16_ff <= HSPM_RST_CONFIG_REG_16;
      config_reg_2c_ff <= HSPM_RST_CONFIG_REG_2C;
      config_reg_2e_ff <= HSPM_RST_CONFIG_REG_2E;
      config_reg_31_ff <= HSPM_RST_CONFIG_REG_31;
      hsir_ff <= HSPM_RST_HSIR;
      pnp_ff <= HSPM_RST_PNP;
    end else begin
      state_ff <= nxt_state;
      config_reg_16_ff <= nxt_config_reg_16;
      config_reg_2c_ff <= nxt_config_reg_2c;
      config_reg_2e_ff <= nxt_config_reg_2e;
      config_reg_31_ff <= nxt_config_reg_31;
      hsir_ff <= nxt_hsir;
      pnp_ff <= nxt_pnp;
    end
  end

  // read mux; the status word reflects live printer/floppy select, the mode bits and state
  always_comb begin
    unique case (wb_adr_i)
      HSPM_OFF_CONFIG_REG_16: rdMux = {24'h000000, config_reg_16_ff};
      HSPM_OFF_CONFIG_REG_2C: rdMux = {24'h000000, config_reg_2c_ff};
      HSPM_OFF_CONFIG_REG_2E: rdMux = {24'h000000, config_reg_2e_ff};
      HSPM_OFF_CONFIG_REG_31: rdMux = {24'h000000, config_reg_31_ff};
      HSPM_OFF_HSIR: rdMux = {24'h000000, hsir_ff};
      HSPM_OFF_PNP: rdMux = {24'h000000, pnp_ff};
      HSPM_OFF_STAT: rdMux = {24'h000000, printerSelected, floppySelected,
                              fullDecodeActive, serialMode, gpioMode, irOutMode,
                              state_ff};
      default: rdMux = HSPM_UNMAPPED;
    endcase
  end

  // one wait state: ack one cycle after the request, dropped the next
  always_ff @(posedge mclk) begin
    if (resetAct) begin
      ack_ff <= 1'b0;
      rdat_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= wb_cyc_i && wb_stb_i && !ack_ff;
      rdat_ff <= rdStrobe ? rdMux : rdat_ff;
    end
  end
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;

  assign printerDetEn = config_reg_16_ff[HSPM_BIT_PRNDET];
  assign gpioMode = config_reg_16_ff[HSPM_BIT_GPIOIRQ];
  assign fullDecode = !config_reg_16_ff[HSPM_BIT_FULLDEC];
  assign serialMode = config_reg_31_ff[HSPM_BIT_SIRQMODE];
  assign irOutMode = hsir_ff[HSPM_BIT_IRDIR];
  assign irFunc = hsir_ff[HSPM_BIT_IRFUNC];

  // without detect enable the port stays a printer
  assign printerSelected = !printerDetEn || printer_not_floppy_sense; // [R1] [R2]
  assign floppySelected = !printerSelected; // [R1]

  assign irqPinA = irqRequestA; // [R3]
  assign irqPinB = irqRequestB; // [R3]
  assign gpio_line_1 = gpioOut[1]; // [R3]
  assign gpio_line_0 = gpioOut[0]; // [R3]
  assign irqPinAOe_n = gpioMode ? !gpioOe[1] : 1'b0; // [R3]
  assign irqPinBOe_n = gpioMode ? !gpioOe[0] : 1'b0; // [R3]

  assign serial_interrupt_out = serialMode ? serialIrqData : 1'b1; // [R4]
  assign parallelIrqOut = serialMode ? 1'b0 : parallelIrq; // [R4]

  // pci clock sampled as data; tick marks its rising edge in serial mode
  always_ff @(posedge mclk) begin
    if (resetAct) begin
      pciClkPrev_ff <= 1'b0;
    end else begin
      pciClkPrev_ff <= pciClkPin;
    end
  end
  assign pciClkTick = serialMode && pciClkPin && !pciClkPrev_ff; // [R5]

  assign fullDecodeActive = fullDecode; // [R7]
  assign sysAddrHigh = fullDecode ? modemAddrPins : 4'h0; // [R7]
  assign configPortAddr = config_reg_16_ff[HSPM_BIT_CFGPORT] ? HSPM_CFG_PORT_HIGH
                                                    : HSPM_CFG_PORT_LOW; // [R9]

  always_ff @(posedge mclk) begin
    if (resetAct) begin
      dmaEnd_ff <= 1'b0;
      smiN_ff <= 1'b1;
    end else begin
      dmaEnd_ff <= terminal_count && dmaActive; // [R12]
      smiN_ff <= !pmEvent; // [R13]
    end
  end
  assign dmaEnd = dmaEnd_ff;
  assign system_mgmt_irq_n = smiN_ff;

  // pnp register low bits pick the line; zero means no line
  always_comb begin
    acpiIrqLines = '0;
    for (int i = 1; i < IRQ_LINES; i++) begin
      if (pnp_ff[3:0] == 4'(i)) begin
        acpiIrqLines[i] = pmEvent; // [R14]
      end
    end
  end

  assign fast_ir_receive = irOutMode ? 1'b0 : fastIrPinIn; // [R15]
  assign fastIrPinOut = irModeSel0; // [R15]
  assign fastIrPinOe_n = !irOutMode; // [R15]

  // pins are active low; status shows asserted as 1
  assign modemStatA = ~modemPinsA; // [R16] [R17] [R18]
  assign modemStatB = ~modemPinsB; // [R16] [R17] [R18]
  assign modemPinsOutA = ~modemReqA; // [R19] [R20]
  assign modemPinsOutB = ~modemReqB; // [R19] [R20]

  assign uart_b_serial_out = irFunc ? irTxData : uartBTxData; // [R21]
  assign ir_receive_shared = irFunc ? uart_b_serial_in : 1'b1; // [R22]
  assign uartBRxData = irFunc ? 1'b1 : uart_b_serial_in; // [R22]

  a_strap_hold: assert property (@(posedge mclk) disable iff (resetAct) // [R24]
    (state_ff == HSPM_ST_RUN && !wrStrobe) |=> $stable(config_reg_16_ff[HSPM_BIT_GPIOIRQ]))
    else $error("gpio select changed without a write");
  a_strap_load: assert property (@(posedge mclk) disable iff (resetAct) // [R11]
    state_ff == HSPM_ST_CAPTURE |=> config_reg_16_ff[HSPM_BIT_GPIOIRQ] == $past(strap_gpio_irq_select))
    else $error("gpio strap not loaded");
  a_cfg_strap: assert property (@(posedge mclk) disable iff (resetAct) // [R9]
    state_ff == HSPM_ST_CAPTURE ##1 !config_reg_16_ff[HSPM_BIT_CFGPORT] |-> configPortAddr == 16'h0250)
    else $error("config port wrong");
  a_printer_route: assert property (@(posedge mclk) disable iff (resetAct) // [R1]
    (printerDetEn && !printer_not_floppy_sense) |-> floppySelected)
    else $error("floppy route missed");
  a_irq_mode: assert property (@(posedge mclk) disable iff (resetAct) // [R3]
    !gpioMode |-> (!irqPinAOe_n && irqPinA == irqRequestA))
    else $error("irq pin not driven");
  a_serial_irq: assert property (@(posedge mclk) disable iff (resetAct) // [R4]
    serialMode |-> (serial_interrupt_out == serialIrqData && !parallelIrqOut))
    else $error("serial irq not routed");
  a_dma_end: assert property (@(posedge mclk) disable iff (resetAct) // [R12]
    (terminal_count && dmaActive) |=> dmaEnd)
    else $error("terminal count ignored");
  a_smi_low: assert property (@(posedge mclk) disable iff (resetAct) // [R13]
    pmEvent |=> !system_mgmt_irq_n)
    else $error("smi not low");
  a_ir_dir: assert property (@(posedge mclk) disable iff (resetAct) // [R15]
    irOutMode |-> (!fastIrPinOe_n && fastIrPinOut == irModeSel0))
    else $error("ir pin direction wrong");
  a_wb_ack: assert property (@(posedge mclk) disable iff (resetAct)
    (wb_cyc_i && wb_stb_i && !ack_ff) |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack timing wrong");
endmodule

// *** shared/hspm_pkg.sv ***
// Purpose: constants and carriers for the host/serial pin mux and straps
// Assumes: one clock, wishbone classic register access
// Notes: register offsets are byte addresses of 32-bit words
package hspm_pkg;
  localparam logic [7:0] HSPM_OFF_CONFIG_REG_16 = 8'h00;
  localparam logic [7:0] HSPM_OFF_CONFIG_REG_2C = 8'h04;
  localparam logic [7:0] HSPM_OFF_CONFIG_REG_2E = 8'h08;
  localparam logic [7:0] HSPM_OFF_CONFIG_REG_31 = 8'h0C;
  localparam logic [7:0] HSPM_OFF_HSIR = 8'h10;
  localparam logic [7:0] HSPM_OFF_PNP = 8'h14;
  localparam logic [7:0] HSPM_OFF_STAT = 8'h18;
  localparam int HSPM_BIT_CFGPORT = 0;
  localparam int HSPM_BIT_PNPDEF = 2;
  localparam int HSPM_BIT_GPIOIRQ = 4;
  localparam int HSPM_BIT_FULLDEC = 6;
  localparam int HSPM_BIT_PRNDET = 7;
  localparam int HSPM_BIT_SIRQMODE = 2;
  localparam int HSPM_BIT_CLKSEL = 0;
  localparam int HSPM_BIT_STRAPFD = 6;
  localparam int HSPM_BIT_IRDIR = 0;
  localparam int HSPM_BIT_IRFUNC = 1;
  localparam logic [7:0] HSPM_RST_CONFIG_REG_16 = 8'h00;
  localparam logic [7:0] HSPM_RST_CONFIG_REG_2C = 8'h00;
  localparam logic [7:0] HSPM_RST_CONFIG_REG_2E = 8'h00;
  localparam logic [7:0] HSPM_RST_CONFIG_REG_31 = 8'h00;
  localparam logic [7:0] HSPM_RST_HSIR = 8'h00;
  localparam logic [7:0] HSPM_RST_PNP = 8'h00;
  localparam logic [15:0] HSPM_CFG_PORT_LOW = 16'h0250;
  localparam logic [15:0] HSPM_CFG_PORT_HIGH = 16'h03F0;
  localparam logic [31:0] HSPM_UNMAPPED = 32'h0000_0000;

  typedef struct packed {
    logic dsr;
    logic dcd;
    logic ri;
    logic cts;
  } hspm_modem_in_t;

  typedef struct packed {
    logic dtr;
    logic rts;
  } hspm_modem_out_t;

  typedef enum logic [1:0] {
    HSPM_ST_RESET = 2'b00,
    HSPM_ST_CAPTURE = 2'b01,
    HSPM_ST_RUN = 2'b10
  } hspm_state_t;
endpackage

// *** dv/hspm_host_model.sv ***
// Purpose: host-side partner raising one dma burst and one power event
// Assumes: single mclk domain, synchronous reset
// Notes: fixed pacing; count lands on the third cycle of the burst
module hspm_host_model (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic go,
  output logic dmaActive,
  output logic terminal_count,
  output logic pmEvent
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] step_ff;
  always_ff @(posedge mclk) begin
    if (!rst_n) step_ff <= 3'h0;
    else if (go) step_ff <= 3'h1;
    else if (step_ff != 3'h0) step_ff <= step_ff + 3'h1;
  end
  assign dmaActive = (step_ff != 3'h0);
  // count while the transfer is still running, so the end is seen mid-burst
  assign terminal_count = (step_ff == 3'h3);
  assign pmEvent = (step_ff == 3'h3);
endmodule

// *** dv/test_hspm_pin_mux.sv ***
// Purpose: register-driven checks of pin steering and strap capture
// Assumes: wishbone classic, ack one cycle after the taking edge
// Notes: combinational pins are looked at on the falling edge, or 1 ns after a read returns
module test_hspm_pin_mux import hspm_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, rst_n = 0, master_reset = 0, wb_we_i = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_ack_o;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic [3:0] wb_sel_i = 4'hF;
  logic strap_full_decode = 0, strap_config_port_select = 1;
  logic strap_pnp_default = 1, strap_gpio_irq_select = 1;
  logic printer_not_floppy_sense = 0, printerSelected, floppySelected;
  logic irqRequestA = 0, irqRequestB = 1, irqPinA, irqPinB, gpio_line_0, gpio_line_1;
  logic irqPinAOe_n, irqPinBOe_n, parallelIrq = 1, serialIrqData = 0;
  logic [1:0] gpioOut = 2'h0, gpioOe = 2'h0;
  logic serial_interrupt_out, parallelIrqOut, pciClkPin = 0, pciClkTick;
  logic [3:0] modemAddrPins = 4'hA;
  logic [15:12] sysAddrHigh;
  logic fullDecodeActive, terminal_count, dmaActive, dmaEnd, pmEvent, system_mgmt_irq_n;
  logic [15:0] configPortAddr;
  logic [7:0] acpiIrqLines;
  logic go = 0, fastIrPinIn = 0, irModeSel0 = 0, fast_ir_receive, fastIrPinOut, fastIrPinOe_n;
  hspm_modem_in_t modemPinsA = 4'hF, modemPinsB = 4'hF, modemStatA, modemStatB;
  hspm_modem_out_t modemReqA = 2'h0, modemReqB = 2'h0, modemPinsOutA, modemPinsOutB;
  logic uartBTxData = 0, irTxData = 0, uart_b_serial_in = 0;
  logic uart_b_serial_out, uartBRxData, ir_receive_shared;
  int miscompares = 0, n_checks = 0;

  hspm_pin_mux dut (.mclk, .rst_n, .master_reset, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_we_i,
    .wb_sel_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .strap_full_decode, .strap_config_port_select,
    .strap_pnp_default, .strap_gpio_irq_select, .printer_not_floppy_sense, .printerSelected,
    .floppySelected, .irqRequestA, .irqRequestB, .gpioOut, .gpioOe, .irqPinA, .irqPinB,
    .gpio_line_0, .gpio_line_1, .irqPinAOe_n, .irqPinBOe_n, .parallelIrq, .serialIrqData,
    .serial_interrupt_out, .parallelIrqOut, .pciClkPin, .pciClkTick, .modemAddrPins,
    .sysAddrHigh, .fullDecodeActive, .configPortAddr, .terminal_count, .dmaActive, .dmaEnd,
    .pmEvent, .system_mgmt_irq_n, .acpiIrqLines, .fastIrPinIn, .irModeSel0, .fast_ir_receive,
    .fastIrPinOut, .fastIrPinOe_n, .modemPinsA, .modemPinsB, .modemStatA, .modemStatB,
    .modemReqA, .modemReqB, .modemPinsOutA, .modemPinsOutB, .uartBTxData, .irTxData,
    .uart_b_serial_in, .uart_b_serial_out, .uartBRxData, .ir_receive_shared);
  hspm_host_model host (.mclk, .rst_n, .go, .dmaActive, .terminal_count, .pmEvent);

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // holds the request until ack is sampled; the next call leaves one idle cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    i = 0;
    @(posedge mclk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge mclk);
      i++;
    end while (wb_ack_o !== 1'b1 && i < 20);
    wb_dat_i <= wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (wb_ack_o !== 1'b1) begin
      miscompares++;
      finish_test();
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    #1 chk(wb_dat_i, e);
  endtask

  initial begin
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    rd(HSPM_OFF_CONFIG_REG_16, 32'h15);
    rd(HSPM_OFF_CONFIG_REG_2E, 32'h0);
    chk(configPortAddr, HSPM_CFG_PORT_HIGH);
    @(posedge mclk);
    {strap_full_decode, strap_config_port_select} <= 2'h2;
    {strap_pnp_default, strap_gpio_irq_select} <= 2'h0;
    gpioOut <= 2'h1;
    gpioOe <= 2'h2;
    rd(HSPM_OFF_CONFIG_REG_16, 32'h15);
    chk({gpio_line_1, gpio_line_0, irqPinAOe_n, irqPinBOe_n}, 4'h5);
    $display("straps done");
    irqRequestA <= 1'b1;
    irqRequestB <= 1'b0;
    wb(1'b1, HSPM_OFF_CONFIG_REG_16, 32'h05);
    @(negedge mclk);
    chk({irqPinA, irqPinB, irqPinAOe_n, irqPinBOe_n}, 4'h8);
    chk({fullDecodeActive, sysAddrHigh}, 5'h1A);
    wb(1'b1, HSPM_OFF_CONFIG_REG_16, 32'h45);
    @(negedge mclk);
    chk({fullDecodeActive, sysAddrHigh}, 5'h00);
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk);
      printer_not_floppy_sense <= i[0];
      wb(1'b1, HSPM_OFF_CONFIG_REG_16, {24'h0, i[1], 7'h45});
      @(negedge mclk);
      chk({printerSelected, floppySelected}, (!i[1] || i[0]) ? 2'h2 : 2'h1);
    end
    wb(1'b1, HSPM_OFF_CONFIG_REG_31, 32'h0);
    @(negedge mclk);
    chk({serial_interrupt_out, parallelIrqOut}, 2'h3);
    wb(1'b1, HSPM_OFF_CONFIG_REG_31, 32'h4);
    for (int i = 0; i < 2; i++) begin
      @(posedge mclk);
      serialIrqData <= i[0];
      pciClkPin <= i[0];
      @(negedge mclk);
      chk({serial_interrupt_out, pciClkTick, parallelIrqOut}, {i[0], i[0], 1'b0});
    end
    $display("pin mux done");
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk);
      {irTxData, uartBTxData, uart_b_serial_in} <= {i[0], !i[0], i[0]};
      {fastIrPinIn, irModeSel0} <= {i[1], !i[1]};
      modemPinsA <= i[0] ? 4'h5 : 4'hC;
      modemPinsB <= i[0] ? 4'hA : 4'h3;
      {modemReqA, modemReqB} <= i[0] ? 4'h3 : 4'h9;
      wb(1'b1, HSPM_OFF_HSIR, i);
      @(negedge mclk);
      chk(fastIrPinOe_n, !i[0]);
      chk(i[0] ? fastIrPinOut : fast_ir_receive, i[0] ? !i[1] : i[1]);
      chk(uart_b_serial_out, i[1] ? i[0] : !i[0]);
      chk(i[1] ? ir_receive_shared : uartBRxData, i[0]);
      chk({modemStatA, modemStatB}, i[0] ? 8'hA5 : 8'h3C);
      chk({modemPinsOutA, modemPinsOutB}, i[0] ? 4'hC : 4'h6);
    end
    $display("ir and modem done");
    wb(1'b1, HSPM_OFF_PNP, 32'h3);
    @(posedge mclk);
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    // looked at off the clock edge, so the model's step count has settled
    for (int i = 0; i < 10 && terminal_count !== 1'b1; i++) @(negedge mclk);
    if (terminal_count !== 1'b1) begin
      miscompares++;
      finish_test();
    end
    chk(acpiIrqLines, 8'h08);
    @(negedge mclk);
    chk({dmaEnd, system_mgmt_irq_n}, 2'h2);
    @(negedge mclk);
    chk({dmaEnd, system_mgmt_irq_n}, 2'h1);
    $display("dma and power done");
    wb(1'b1, HSPM_OFF_PNP, 32'h3);
    rd(HSPM_OFF_PNP, 32'h3);
    wb(1'b1, HSPM_OFF_CONFIG_REG_2C, 32'hFFFF_FF01);
    rd(HSPM_OFF_CONFIG_REG_2C, 32'h1);
    rd(8'h1C, HSPM_UNMAPPED);
    @(posedge mclk);
    master_reset <= 1'b1;
    repeat (2) @(posedge mclk);
    master_reset <= 1'b0;
    repeat (3) @(posedge mclk);
    rd(HSPM_OFF_CONFIG_REG_31, 32'h0);
    rd(HSPM_OFF_CONFIG_REG_16, 32'h40);
    rd(HSPM_OFF_CONFIG_REG_2E, 32'h40);
    chk(configPortAddr, HSPM_CFG_PORT_LOW);
    rd(HSPM_OFF_STAT, 32'h82);
    $display("registers and reset done");
    finish_test();
  end
endmodule
